// file: fault_resolver.sv
// Fault resolver: picks one fault from a vector and gives its reaction and code.
// Assumes fault flags are synchronous to sys_clk.
`timescale 1ns/1ps
module fault_resolver
  import prs_pkg::*;
(
  input  wire logic [NFAULT-1:0]   fault_in,    // Fault flags
  input  wire logic [2*NFAULT-1:0] react_cfg,   // Two reaction bits per fault
  input  wire logic                debug_hold,  // Debug stop option
  output logic                     any_fault,   // Some fault active
  output react_t                   reaction,    // Resolved reaction
  output logic [15:0]              err_code     // Code of chosen fault
);

  react_t react_map [NFAULT];

  genvar g;
  generate
    for (g = 0; g < NFAULT; g++) begin : g_map
      always_comb begin
        if (g == FAULT_ADC_WD)
          react_map[g] = REACT_FAST;
        else if (g == FAULT_IN_UV)
          react_map[g] = REACT_AUTO;
        else
          react_map[g] = react_t'(react_cfg[2*g +: 2]);
      end
    end
  endgenerate

  always_comb begin
    any_fault = |fault_in;
    reaction  = REACT_AUTO;
    err_code  = 16'h0000;
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (fault_in[i]) begin
        reaction = react_map[i];
        err_code = 16'((32'(ERR_BASE) << i) >> FAULT_IN_UV);
      end
    end
    if (debug_hold && !(fault_in == (NFAULT'(1) << FAULT_SUPPLY_UV))) begin
      reaction = REACT_STOP;
    end
  end

endmodule

// file: protection_reaction_sequencer.sv
// Protection reaction sequencer with AXI4-Lite register access.
// Assumes fault flags and supply comparators arrive asynchronously.
//
// Summary of operation
// - Gate driver shuts off within 1/512 operation cycle of any protection.
// - Latch reaction holds until supply falls below off threshold.
// - Auto-restart enters power save two for 0.4 s to 4 s wait.
// - Fast auto-restart waits a fixed 0.4 s in power save two.
// - Startup cell keeps supply between low and high levels while reacting, except in stop.
// - Stop reaction never recharges supply; supply loss restarts everything.
// - One discharge pulse of configured width after restart wait.
// - After pulse and recharge, gate is re-enabled for pre-startup check.
// - Check pass leads to startup, regulated; new fault restarts sequence.
// - Debug hold forces stop for all faults except supply lockout.
// - Error code records last fault; 0040 means input undervoltage.
// - Converter watchdog timeout selects fast auto-restart.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module protection_reaction_sequencer
  import prs_pkg::*;
(
  input  wire logic              sys_clk,          // Core clock
  input  wire logic              srst,             // Sync reset, high
  input  wire logic              clk_en,           // Clock enable
  input  wire logic [NFAULT-1:0] fault_in,         // Fault flags, async
  input  wire logic              supply_off_threshold,         // Below off level
  input  wire logic              supply_low_regulation_level,  // Below low level
  input  wire logic              supply_high_regulation_level, // Above high level
  input  wire logic              startup_done,     // Startup phase finished
  output logic                   gate_en,          // Gate driver enable
  output logic                   gate_pulse,       // Discharge pulse on gate
  output logic                   high_voltage_startup_input, // Startup cell on
  output logic                   power_save_level_two, // Power save state
  output logic                   irq,              // Interrupt level
  input  wire logic [7:0]        s_axi_awaddr,     // Write address
  input  wire logic              s_axi_awvalid,    // Write address valid
  output logic                   s_axi_awready,    // Write address ready
  input  wire logic [31:0]       s_axi_wdata,      // Write data
  input  wire logic [3:0]        s_axi_wstrb,      // Write strobes
  input  wire logic              s_axi_wvalid,     // Write data valid
  output logic                   s_axi_wready,     // Write data ready
  output logic [1:0]             s_axi_bresp,      // Write response
  output logic                   s_axi_bvalid,     // Write response valid
  input  wire logic              s_axi_bready,     // Write response ready
  input  wire logic [7:0]        s_axi_araddr,     // Read address
  input  wire logic              s_axi_arvalid,    // Read address valid
  output logic                   s_axi_arready,    // Read address ready
  output logic [31:0]            s_axi_rdata,      // Read data
  output logic [1:0]             s_axi_rresp,      // Read response
  output logic                   s_axi_rvalid,     // Read valid
  input  wire logic              s_axi_rready      // Read ready
);

  // Input synchronisers
  logic [NFAULT+2:0] sync1_r, sync2_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clk_en) begin
      sync1_r <= {supply_high_regulation_level, supply_low_regulation_level,
                  supply_off_threshold, fault_in};
      sync2_r <= sync1_r;
    end
  end
  logic [NFAULT-1:0] flt_s;
  logic              off_s, low_s, high_s;
  assign flt_s  = sync2_r[NFAULT-1:0];
  assign off_s  = sync2_r[NFAULT];
  assign low_s  = sync2_r[NFAULT+1];
  assign high_s = sync2_r[NFAULT+2];

  // Registers
  logic [31:0] ctrl_r, ctrl_nxt, wait_ms_r, wait_ms_nxt, pulse_r, pulse_nxt;
  logic [31:0] react_r, react_nxt;
  logic [15:0] err_r, err_nxt;
  logic [NIRQ-1:0] ist_r, ist_nxt, ien_r, ien_nxt;

  // Resolver
  logic        any_fault;
  react_t      reaction;
  logic [15:0] code;
  fault_resolver u_res (
    .fault_in   (flt_s),
    .react_cfg  (react_r[2*NFAULT-1:0]),
    .debug_hold (ctrl_r[CTRL_DEBUG_BIT]),
    .any_fault  (any_fault),
    .reaction   (reaction),
    .err_code   (code)
  );

  // Sequencer state
  seq_st_t     st_r, st_nxt;
  react_t      react_r2, react_nxt2;
  logic [31:0] cnt_r, cnt_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic        hv_r, hv_nxt;
  logic        fault_ev, run_ev, latch_ev;

  always_comb begin
    st_nxt     = st_r;
    react_nxt2 = react_r2;
    cnt_nxt    = cnt_r;
    ms_nxt     = ms_r;
    hv_nxt     = hv_r;
    fault_ev   = 1'b0;
    run_ev     = 1'b0;
    latch_ev   = 1'b0;
    if (low_s)
      hv_nxt = 1'b1;
    else if (high_s)
      hv_nxt = 1'b0;
    unique case (st_r)
      ST_OFF: begin
        hv_nxt = 1'b1;
        if (!off_s && !low_s) st_nxt = ST_PRECHECK;
      end
      ST_PRECHECK: begin
        hv_nxt = 1'b0;
        if (ctrl_r[CTRL_PRE_OK_BIT]) st_nxt = ST_STARTUP;
      end
      ST_STARTUP: begin
        hv_nxt = 1'b0;
        if (startup_done) begin
          st_nxt = ST_REGULATED;
          run_ev = 1'b1;
        end
      end
      ST_REGULATED: hv_nxt = 1'b0;
      ST_SHUTDOWN: begin
        unique case (react_r2)
          REACT_LATCH: begin
            st_nxt   = ST_LATCHED;
            latch_ev = 1'b1;
          end
          REACT_STOP: st_nxt = ST_STOP;
          default: st_nxt = ST_WAIT;
        endcase
        cnt_nxt = '0;
        ms_nxt  = '0;
      end
      ST_LATCHED: ;
      ST_STOP: hv_nxt = 1'b0;
      ST_WAIT: begin
        if (cnt_r == 32'(CYC_PER_MS - 1)) begin
          cnt_nxt = '0;
          ms_nxt  = ms_r + 16'd1;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
        if ((react_r2 == REACT_FAST) ? (ms_r >= 16'(FAST_RESTART_MS))
                                     : (ms_r >= wait_ms_r[15:0])) begin
          st_nxt  = ST_PULSE;
          cnt_nxt = '0;
        end
      end
      ST_PULSE: begin
        cnt_nxt = cnt_r + 32'd1;
        // A zero width still ends after one cycle instead of hanging
        if (cnt_r + 32'd1 >= pulse_r) st_nxt = ST_RECHARGE;
      end
      ST_RECHARGE: begin
        if (!hv_r && !low_s) st_nxt = ST_PRECHECK;
      end
      default: st_nxt = ST_OFF;
    endcase
    if (any_fault && (st_r == ST_PRECHECK || st_r == ST_STARTUP ||
                      st_r == ST_REGULATED)) begin
      st_nxt     = ST_SHUTDOWN;
      react_nxt2 = reaction;
      fault_ev   = 1'b1;
    end
    if (off_s) begin
      st_nxt = ST_OFF;
      hv_nxt = (st_r != ST_STOP) && (st_r != ST_OFF);
    end
    if (st_r == ST_STOP) hv_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r     <= ST_OFF;
      react_r2 <= REACT_AUTO;
      cnt_r    <= '0;
      ms_r     <= '0;
      hv_r     <= 1'b0;
    end else if (clk_en) begin
      st_r     <= st_nxt;
      react_r2 <= react_nxt2;
      cnt_r    <= cnt_nxt;
      ms_r     <= ms_nxt;
      hv_r     <= hv_nxt;
    end
  end

  assign gate_en = (st_r == ST_PRECHECK || st_r == ST_STARTUP || st_r == ST_REGULATED)
                   && !any_fault;
  assign gate_pulse = (st_r == ST_PULSE);
  assign high_voltage_startup_input = hv_r;
  assign power_save_level_two = (st_r == ST_WAIT);
  assign irq = |(ist_r & ien_r);

  // AXI4-Lite slave
  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        do_wr;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) if (s[b]) m[8*b +: 8] = n[8*b +: 8];
    return m;
  endfunction

  always_comb begin
    aw_nxt = aw_r; w_nxt = w_r; b_nxt = b_r; r_nxt = r_r;
    awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
    bresp_nxt = bresp_r; rresp_nxt = rresp_r; rd_nxt = rd_r;
    ctrl_nxt = ctrl_r; wait_ms_nxt = wait_ms_r; pulse_nxt = pulse_r;
    react_nxt = react_r; ien_nxt = ien_r; err_nxt = err_r;
    ist_nxt = ist_r;
    do_wr = aw_r && w_r && !b_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_nxt = 1'b1; awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_nxt = 1'b1; wd_nxt = s_axi_wdata; ws_nxt = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_nxt = 1'b0; w_nxt = 1'b0; b_nxt = 1'b1; bresp_nxt = RESP_OKAY;
      unique case (awa_r)
        CTRL_OFS:    ctrl_nxt = merge(ctrl_r, wd_r, ws_r);
        RESTART_OFS: begin
          wait_ms_nxt = merge(wait_ms_r, wd_r, ws_r);
          if (wait_ms_nxt < 32'(RESTART_MIN_MS)) wait_ms_nxt = 32'(RESTART_MIN_MS);
          if (wait_ms_nxt > 32'(RESTART_MAX_MS)) wait_ms_nxt = 32'(RESTART_MAX_MS);
        end
        PULSE_OFS:   pulse_nxt = merge(pulse_r, wd_r, ws_r);
        REACT_OFS:   react_nxt = merge(react_r, wd_r, ws_r);
        IRQ_EN_OFS:  ien_nxt = NIRQ'(merge(32'(ien_r), wd_r, ws_r));
        IRQ_CLR_OFS: if (ws_r[0]) ist_nxt = ist_r & ~wd_r[NIRQ-1:0];
        STATUS_OFS, ERRCODE_OFS, IRQ_STAT_OFS: ;
        default:     bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (b_r && s_axi_bready) b_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt = 1'b1; rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS:     rd_nxt = ctrl_r;
        RESTART_OFS:  rd_nxt = wait_ms_r;
        PULSE_OFS:    rd_nxt = pulse_r;
        REACT_OFS:    rd_nxt = react_r;
        STATUS_OFS:   rd_nxt = {26'h0, hv_r, gate_en, st_r};
        ERRCODE_OFS:  rd_nxt = {16'h0, err_r};
        IRQ_STAT_OFS: rd_nxt = 32'(ist_r);
        IRQ_EN_OFS:   rd_nxt = 32'(ien_r);
        IRQ_CLR_OFS:  rd_nxt = 32'h0;
        default: begin
          rd_nxt = 32'h0; rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (r_r && s_axi_rready) begin
      r_nxt = 1'b0;
    end
    if (fault_ev) err_nxt = code;
    // Events win over clear
    if (fault_ev) ist_nxt[IRQ_FAULT] = 1'b1;
    if (run_ev)   ist_nxt[IRQ_RUN]   = 1'b1;
    if (latch_ev) ist_nxt[IRQ_LATCH] = 1'b1;
  end

  // Handshakes pause with the clock enable so no transfer is lost
  assign s_axi_awready = clk_en && !aw_r && !b_r;
  assign s_axi_wready  = clk_en && !w_r && !b_r;
  assign s_axi_arready = clk_en && !r_r;
  assign s_axi_bvalid  = clk_en && b_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = clk_en && r_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_r <= 1'b0; w_r <= 1'b0; b_r <= 1'b0; r_r <= 1'b0;
      awa_r <= '0; wd_r <= '0; ws_r <= '0; rd_r <= '0;
      bresp_r <= RESP_OKAY; rresp_r <= RESP_OKAY;
      ctrl_r <= '0;
      wait_ms_r <= 32'(RESTART_RESET_MS);
      pulse_r <= 32'(PULSE_RESET);
      react_r <= 32'(REACT_RESET);
      ien_r <= '0; ist_r <= '0; err_r <= '0;
    end else if (clk_en) begin
      aw_r <= aw_nxt; w_r <= w_nxt; b_r <= b_nxt; r_r <= r_nxt;
      awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt; rd_r <= rd_nxt;
      bresp_r <= bresp_nxt; rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt; wait_ms_r <= wait_ms_nxt; pulse_r <= pulse_nxt;
      react_r <= react_nxt; ien_r <= ien_nxt; ist_r <= ist_nxt; err_r <= err_nxt;
    end
  end

endmodule

// file: protection_reaction_sequencer_chk.sv
// Port checker for the protection reaction sequencer.
// Assumes clk_en high during bus traffic; bound to the top module.
`timescale 1ns/1ps
module protection_reaction_sequencer_chk
  import prs_pkg::*;
(
  input wire logic              sys_clk,                      // Core clock
  input wire logic              srst,                         // Sync reset
  input wire logic              clk_en,                       // Clock enable
  input wire logic [NFAULT-1:0] fault_in,                     // Fault flags
  input wire logic              supply_off_threshold,         // Below off level
  input wire logic              supply_high_regulation_level, // Above high level
  input wire logic              gate_en,                      // Gate enable
  input wire logic              gate_pulse,                   // Discharge pulse
  input wire logic              high_voltage_startup_input,   // Cell on
  input wire logic              power_save_level_two,         // Restart wait
  input wire logic              s_axi_awvalid,                // Bus
  input wire logic              s_axi_awready,                // Bus
  input wire logic              s_axi_wvalid,                 // Bus
  input wire logic              s_axi_wready,                 // Bus
  input wire logic              s_axi_bvalid,                 // Bus
  input wire logic              s_axi_arvalid,                // Bus
  input wire logic              s_axi_arready,                // Bus
  input wire logic              s_axi_rvalid                  // Bus
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_gate_off_fast: assert property ((clk_en && |fault_in) [*3] |-> !gate_en)
    else $error("gate still on after fault");
  a_wait_gate_off: assert property (power_save_level_two |-> !gate_en && !gate_pulse)
    else $error("gate active during restart wait");
  a_pulse_no_gate: assert property (gate_pulse |-> !gate_en)
    else $error("pulse overlaps gate enable");
  a_off_quiet: assert property ((clk_en && supply_off_threshold) [*4] |->
    !gate_en && !gate_pulse && !power_save_level_two)
    else $error("activity with supply below off level");
  a_cell_off_high: assert property ($rose(supply_high_regulation_level) |->
    ##[1:4] !high_voltage_startup_input)
    else $error("startup cell on above high level");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_busy_no_take: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind protection_reaction_sequencer protection_reaction_sequencer_chk chk (
  .sys_clk, .srst, .clk_en, .fault_in, .supply_off_threshold,
  .supply_high_regulation_level, .gate_en, .gate_pulse, .high_voltage_startup_input,
  .power_save_level_two, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// file: protection_reaction_sequencer_tb.sv
// Self-checking bench for the protection reaction sequencer.
// Assumes the supply model on the far side; restart waits are too long to expire.
`timescale 1ns/1ps
module protection_reaction_sequencer_tb
  import prs_pkg::*;
;
  logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, line_off = 1'b0;
  logic [NFAULT-1:0] fault_in = '0;
  logic supply_off_threshold, supply_low_regulation_level, supply_high_regulation_level;
  logic startup_done, gate_en, gate_pulse, high_voltage_startup_input;
  logic power_save_level_two, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat, pw, seed = 32'hb553;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int mismatches = 0, num_checks = 0, cycles = 0, c;

  protection_reaction_sequencer dut (.sys_clk, .srst, .clk_en, .fault_in,
    .supply_off_threshold, .supply_low_regulation_level, .supply_high_regulation_level,
    .startup_done, .gate_en, .gate_pulse, .high_voltage_startup_input,
    .power_save_level_two, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  supply_stage_model far (.sys_clk, .rst(srst), .hv_on(high_voltage_startup_input),
    .gate_on(gate_en), .line_off, .below_off(supply_off_threshold),
    .below_low(supply_low_regulation_level), .above_high(supply_high_regulation_level),
    .start_done(startup_done));

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Lowest flagged fault names the code
  function automatic logic [31:0] exp_err(input logic [7:0] m);
    for (int i = 0; i < 8; i++) if (m[i]) return {16'h0, ERR_BASE << i};
    return 32'h0;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(nm, e, rdat);
  endtask
  task automatic st(input seq_st_t e);
    rd(STATUS_OFS);
    check("state", {28'h0, e}, {28'h0, rdat[3:0]});
  endtask
  task automatic bring_up(input logic [31:0] ctrl);
    @(posedge sys_clk);
    srst <= 1'b1;
    line_off <= 1'b0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    wr(PULSE_OFS, pw);
    wr(IRQ_EN_OFS, 32'h7);
    wr(CTRL_OFS, ctrl);
    c = 0;
    while (gate_en !== 1'b1 && c < 300) begin
      @(negedge sys_clk);
      c++;
    end
    check("gate_en", 1, gate_en);
    repeat (30) @(posedge sys_clk);
    st(ST_REGULATED);
  endtask
  // Fault mask with reaction table, held a random time
  task automatic hit(input logic [7:0] m, input logic [15:0] rc, input seq_st_t e);
    wr(REACT_OFS, {16'h0, rc});
    @(posedge sys_clk);
    fault_in <= m;
    repeat (4 + int'(seed[2:0])) @(posedge sys_clk);
    seed = lfsr(seed);
    fault_in <= '0;
    @(negedge sys_clk);
    check("gate_en", 0, gate_en);
    repeat (20) @(posedge sys_clk);
    st(e);
    rchk("err_code", ERRCODE_OFS, exp_err(m));
  endtask
  task automatic count_hv(input int n);
    c = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (high_voltage_startup_input === 1'b1) c++;
    end
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rchk("restart", RESTART_OFS, 32'd1200);
    rchk("pulse", PULSE_OFS, 32'd100);
    rchk("react", REACT_OFS, 32'h0);
    rchk("ctrl", CTRL_OFS, 32'h0);
    rd(8'h24);
    check("unmapped resp", RESP_SLVERR, resp);
    check("unmapped data", 0, rdat);
    wr(ERRCODE_OFS, 32'hffff);
    check("ro resp", RESP_OKAY, resp);
    rchk("err_code", ERRCODE_OFS, 32'h0);
    wr(RESTART_OFS, 32'd100);
    rchk("restart low", RESTART_OFS, 32'd400);
    wr(RESTART_OFS, 32'd5000);
    rchk("restart high", RESTART_OFS, 32'd4000);
    $display("test registers done");
    pw = {24'h0, seed[7:0] | 8'h01};
    seed = lfsr(seed);
    bring_up(32'h2);
    rchk("pulse", PULSE_OFS, pw);
    hit(8'h04, 16'h0010, ST_LATCHED);
    rchk("irq_stat", IRQ_STAT_OFS, 32'h7);
    check("irq", 1, irq);
    wr(IRQ_CLR_OFS, 32'h7);
    check("irq", 0, irq);
    count_hv(300);
    check("cell used", 1, c > 0);
    line_off <= 1'b1;
    repeat (200) @(posedge sys_clk);
    st(ST_OFF);
    $display("test latch done");
    bring_up(32'h2);
    hit(8'h08, 16'h00c0, ST_STOP);
    // Clock enable low freezes the stop state while the supply drains
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (100) @(posedge sys_clk);
    clk_en <= 1'b1;
    st(ST_STOP);
    count_hv(40);
    check("cell idle", 0, c);
    repeat (150) @(posedge sys_clk);
    st(ST_OFF);
    $display("test stop done");
    bring_up(32'h2);
    hit(8'h01, 16'hffff, ST_WAIT);
    check("power save", 1, power_save_level_two);
    wr(IRQ_EN_OFS, 32'h0);
    check("irq masked", 0, irq);
    wr(IRQ_EN_OFS, 32'h1);
    check("irq", 1, irq);
    bring_up(32'h2);
    hit(8'h02, 16'hffff, ST_WAIT);
    check("power save", 1, power_save_level_two);
    bring_up(32'h2);
    hit(8'h24, 16'h0010, ST_LATCHED);
    $display("test restart done");
    // debug hold stops all but lockout
    bring_up(32'h3);
    hit(8'h04, 16'h0010, ST_STOP);
    bring_up(32'h3);
    hit(8'h80, 16'h0000, ST_WAIT);
    wr(CTRL_OFS, 32'h2);
    $display("test debug done");
    complete_run();
  end
endmodule

// file: prs_pkg.sv
// Package: constants for the protection reaction sequencer.
// Assumes a 20 MHz sys_clk and a 32-bit AXI4-Lite register bus.
package prs_pkg;

  localparam int CLK_HZ = 20000000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] RESTART_OFS  = 8'h04;
  localparam logic [7:0] PULSE_OFS    = 8'h08;
  localparam logic [7:0] REACT_OFS    = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] ERRCODE_OFS  = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h1c;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h20;

  // Control fields
  localparam int CTRL_DEBUG_BIT = 0;
  localparam int CTRL_PRE_OK_BIT = 1;

  // Fault vector layout
  localparam int NFAULT = 8;
  localparam int FAULT_IN_UV  = 0;
  localparam int FAULT_ADC_WD = 1;
  localparam int FAULT_SUPPLY_UV = 7;

  // Error code per fault: one-hot shifted, input undervoltage = 0040
  localparam logic [15:0] ERR_BASE = 16'h0040;

  // Reactions
  typedef enum logic [1:0] {
    REACT_AUTO, REACT_LATCH, REACT_FAST, REACT_STOP
  } react_t;
  localparam logic [15:0] REACT_RESET = 16'h0000;

  // Timing: restart wait in ms, 400 .. 4000
  localparam int RESTART_MIN_MS  = 400;
  localparam int RESTART_MAX_MS  = 4000;
  localparam int FAST_RESTART_MS = 400;
  localparam logic [15:0] RESTART_RESET_MS = 16'd1200;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Operation cycle in us; gate off within 1/512 of it
  localparam int OP_CYCLE_US = 10000;
  localparam int GATE_OFF_NS = OP_CYCLE_US * 1000 / 512;
  // Scaled in this order so the product stays inside 32 bits
  localparam int GATE_OFF_CYC = GATE_OFF_NS * (CLK_HZ / 1000000) / 1000;
  // Discharge pulse width in cycles
  localparam logic [15:0] PULSE_RESET = 16'd100;

  // Irq bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_RUN   = 1;
  localparam int IRQ_LATCH = 2;
  localparam int NIRQ = 3;

  typedef enum logic [3:0] {
    ST_OFF, ST_PRECHECK, ST_STARTUP, ST_REGULATED, ST_SHUTDOWN,
    ST_LATCHED, ST_WAIT, ST_PULSE, ST_RECHARGE, ST_STOP
  } seq_st_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: supply_stage_model.sv
// Behavioural supply and power stage seen from the sequencer.
// Assumes one sys_clk; line_off removes mains so the cell cannot charge.
`timescale 1ns/1ps
module supply_stage_model (
  input  wire logic sys_clk,    // Core clock
  input  wire logic rst,        // Sync reset, high
  input  wire logic hv_on,      // Startup cell on
  input  wire logic gate_on,    // Gate driver on
  input  wire logic line_off,   // Mains removed
  output logic      below_off,  // Below off level
  output logic      below_low,  // Below low level
  output logic      above_high, // Above high level
  output logic      start_done  // Startup finished
);
  int vcc = 60;
  int run = 0;
  // Switching supplies itself; idle stage drains one step a cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      vcc <= 60;
      run <= 0;
    end else begin
      if (hv_on && !line_off) vcc <= (vcc > 97) ? 100 : vcc + 2;
      else if (line_off || !gate_on) vcc <= (vcc < 1) ? 0 : vcc - 1;
      run <= gate_on ? run + 1 : 0;
    end
  end
  assign below_off  = vcc < 10;
  assign below_low  = vcc < 40;
  assign above_high = vcc > 80;
  assign start_done = run > 20;
endmodule
